/* rtl/rdqf_pkg.sv */
/*
  Package for the receive descriptor queue fetch block: register offsets,
  descriptor field layout, reset values and enumerations.
  Assumes an APB register port and an AHB-Lite master port, 32-bit data.
*/
package rdqf_pkg;

  // Register byte offsets on APB.
  localparam logic [7:0] OFS_QUEUE_BASE    = 8'h00;
  localparam logic [7:0] OFS_QUEUE_LENGTH  = 8'h04;
  localparam logic [7:0] OFS_CURRENT_PTR   = 8'h08;
  localparam logic [7:0] OFS_ENQUEUE_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CONTROL       = 8'h10;
  localparam logic [7:0] OFS_STATUS        = 8'h14;

  // Second descriptor word layout.
  localparam int NO_FRAME_START_FLAG_BIT  = 31;
  localparam int TAG_LSB   = 16;
  localparam int TAG_MSB   = 30;
  localparam int LEN_LSB   = 0;
  localparam int LEN_MSB   = 15;

  // Enqueue write field width, and count, address and length reset values.
  localparam int          ENQ_ADD_W   = 8;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
  localparam logic [15:0] LENGTH_RST  = 16'h0000;

  // Bytes per descriptor and per word.
  localparam logic [31:0] DESC_BYTES  = 32'h0000_0008;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;

  // AHB encodings.
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HBURST_INCR   = 3'h1;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    RDQF_DISP_NONE,
    RDQF_DISP_SKIP_ZERO,
    RDQF_DISP_SKIP_NO_FRAME_START_FLAG,
    RDQF_DISP_USED
  } rdqf_disp_e;

endpackage

/* rtl/rdqf_desc_slot.sv */
/*
  Local descriptor store: holds one fetched descriptor and hands it to
  the receive data path, deciding whether the buffer is used or dropped.
  Assumes the data path reports whether a frame is in progress.
*/
`timescale 1ns/10ps
module rdqf_desc_slot (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Load side.
  input  wire logic        load_valid,
  input  wire logic [31:0] load_addr,
  input  wire logic [31:0] load_ctrl,
  output logic             load_ready,
  // Data path side.
  input  wire logic        frame_in_progress,
  input  wire logic        buf_take,
  output logic             buf_valid,
  output logic [31:0]      buf_addr,
  output logic [15:0]      buf_byte_length,
  output logic [14:0]      buf_tag,
  output logic             buf_no_frame_start,
  output rdqf_pkg::rdqf_disp_e last_disp
);

  logic        full_q;
  logic [31:0] addr_q;
  logic [31:0] ctrl_q;
  logic        zero_len;
  logic        no_frame_start_flag_drop;

  assign zero_len  = (ctrl_q[rdqf_pkg::LEN_MSB:rdqf_pkg::LEN_LSB] == 16'h0000);
  assign no_frame_start_flag_drop = ctrl_q[rdqf_pkg::NO_FRAME_START_FLAG_BIT] && !frame_in_progress;
  // Dropped buffers never reach the data path, so no status can be posted.
  assign buf_valid          = full_q && !zero_len && !no_frame_start_flag_drop;
  assign buf_addr           = addr_q;
  assign buf_byte_length    = ctrl_q[rdqf_pkg::LEN_MSB:rdqf_pkg::LEN_LSB];
  assign buf_tag            = ctrl_q[rdqf_pkg::TAG_MSB:rdqf_pkg::TAG_LSB];
  assign buf_no_frame_start = ctrl_q[rdqf_pkg::NO_FRAME_START_FLAG_BIT];
  assign load_ready         = !full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      ctrl_q <= 32'h0000_0000;
    end else if (load_valid && !full_q) begin
      full_q <= 1'b1;
      addr_q <= load_addr;
      ctrl_q <= load_ctrl;
    end else if (full_q && (zero_len || no_frame_start_flag_drop || buf_take)) begin
      full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_disp <= rdqf_pkg::RDQF_DISP_NONE;
    end else if (full_q && zero_len) begin
      last_disp <= rdqf_pkg::RDQF_DISP_SKIP_ZERO;
    end else if (full_q && no_frame_start_flag_drop) begin
      last_disp <= rdqf_pkg::RDQF_DISP_SKIP_NO_FRAME_START_FLAG;
    end else if (full_q && buf_take) begin
      last_disp <= rdqf_pkg::RDQF_DISP_USED;
    end
  end

endmodule

/* rtl/rdqf_fetch.sv */
/*
  Receive descriptor queue fetch engine: APB registers, AHB master that
  burst-reads two-word descriptors, and the available-descriptor count.
  Assumes a single-layer AHB-Lite bus with OKAY responses and a data path
  that consumes buffers and writes status only after its data is written.
*/
// Register access over APB and the register offsets were left to the implementer.
// Notes on behaviour
// - Block masters AHB itself for descriptor reads.
// - Descriptor and status queues live in host memory.
// - Descriptors fetched with two-beat INCR bursts.
// - Word one is buffer address pointer.
// - Word two: flag bit31, tag, length.
// - Length is maximum bytes for the buffer.
// - Zero-length descriptors skipped without status.
// - Buffer tag kept and carried to status.
// - Flagged buffer only continues a frame.
// - Enqueue write adds to the available total.
// - Each fetch subtracts one from the total.
// - Enqueue read returns unfetched valid total.
// - Status written only after data completes.
`timescale 1ns/10ps
module rdqf_fetch (
  // APB clock, reset and register port.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // AHB master port.
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic [2:0]       hburst,
  output logic [2:0]       hsize,
  output logic             hwrite,
  output logic [31:0]      hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hready,
  input  wire logic        hresp,
  // Receive data path.
  input  wire logic        frame_in_progress,
  input  wire logic        buf_take,
  output logic             buf_valid,
  output logic [31:0]      buf_addr,
  output logic [15:0]      buf_byte_length,
  output logic [14:0]      buf_tag,
  output logic             buf_no_frame_start
);

  typedef enum logic [1:0] {
    RDQF_IDLE,
    RDQF_ADDR0,
    RDQF_ADDR1,
    RDQF_DATA1
  } rdqf_state_e;

  rdqf_state_e state_q;
  logic [31:0] base_q;
  logic [15:0] length_q;
  logic [31:0] cur_q;
  logic [15:0] count_q;
  logic        enable_q;
  logic        err_q;
  logic [31:0] word0_q;
  logic        load_valid;
  logic        load_ready;
  logic        fetch_done;
  logic        apb_wr;
  logic        enq_wr;
  logic        addr_ok;
  logic [31:0] last_slot;
  rdqf_pkg::rdqf_disp_e last_disp;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == rdqf_pkg::OFS_QUEUE_BASE) || (a == rdqf_pkg::OFS_QUEUE_LENGTH) ||
             (a == rdqf_pkg::OFS_CURRENT_PTR) || (a == rdqf_pkg::OFS_ENQUEUE_COUNT) ||
             (a == rdqf_pkg::OFS_CONTROL) || (a == rdqf_pkg::OFS_STATUS);
  endfunction

  assign addr_ok = is_reg(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign apb_wr  = psel && penable && pwrite && addr_ok;
  assign enq_wr  = apb_wr && (paddr == rdqf_pkg::OFS_ENQUEUE_COUNT);

  // Address of the final descriptor slot; a length that is a multiple of 8 bytes keeps this exact.
  assign last_slot = base_q + {16'h0000, length_q} - rdqf_pkg::DESC_BYTES;

  assign fetch_done = (state_q == RDQF_DATA1) && hready;
  assign load_valid = fetch_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q   <= rdqf_pkg::ADDR_RST;
      length_q <= rdqf_pkg::LENGTH_RST;
      enable_q <= 1'b0;
    end else if (apb_wr) begin
      unique case (paddr)
        rdqf_pkg::OFS_QUEUE_BASE:   base_q   <= {pwdata[31:2], 2'b00};
        rdqf_pkg::OFS_QUEUE_LENGTH: length_q <= pwdata[15:0];
        rdqf_pkg::OFS_CONTROL:      enable_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Current pointer: host sets it, fetches advance and wrap it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= rdqf_pkg::ADDR_RST;
    end else if (fetch_done) begin
      if (cur_q == last_slot) begin
        cur_q <= base_q;
      end else begin
        cur_q <= cur_q + rdqf_pkg::DESC_BYTES;
      end
    end else if (apb_wr && paddr == rdqf_pkg::OFS_CURRENT_PTR) begin
      cur_q <= {pwdata[31:2], 2'b00};
    end
  end

  // Count takes the add and the fetch in the same cycle, so neither is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= rdqf_pkg::COUNT_RST;
    end else begin
      count_q <= count_q + (enq_wr ? {8'h00, pwdata[rdqf_pkg::ENQ_ADD_W-1:0]} : 16'h0000)
                         - (fetch_done ? 16'h0001 : 16'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (hresp && state_q != RDQF_IDLE) begin
      err_q <= 1'b1;
    end else if (apb_wr && paddr == rdqf_pkg::OFS_STATUS && pwdata[0]) begin
      err_q <= 1'b0;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      rdqf_pkg::OFS_QUEUE_BASE:    prdata = base_q;
      rdqf_pkg::OFS_QUEUE_LENGTH:  prdata = {16'h0000, length_q};
      rdqf_pkg::OFS_CURRENT_PTR:   prdata = cur_q;
      rdqf_pkg::OFS_ENQUEUE_COUNT: prdata = {16'h0000, count_q};
      rdqf_pkg::OFS_CONTROL:       prdata = {31'h0, enable_q};
      rdqf_pkg::OFS_STATUS:        prdata = {27'h0, buf_valid, (state_q != RDQF_IDLE), last_disp, err_q};
      default:                     prdata = 32'h0000_0000;
    endcase
  end

  // Two-beat burst: address phase of beat 1 overlaps data phase of beat 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RDQF_IDLE;
    end else begin
      unique case (state_q)
        RDQF_IDLE:  if (enable_q && count_q != 16'h0000 && load_ready && !err_q) state_q <= RDQF_ADDR0;
        RDQF_ADDR0: if (hready) state_q <= RDQF_ADDR1;
        RDQF_ADDR1: if (hready) state_q <= RDQF_DATA1;
        RDQF_DATA1: if (hready) state_q <= RDQF_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word0_q <= 32'h0000_0000;
    end else if (state_q == RDQF_ADDR1 && hready) begin
      word0_q <= hrdata;
    end
  end

  always_comb begin
    haddr  = cur_q;
    htrans = rdqf_pkg::HTRANS_IDLE;
    unique case (state_q)
      RDQF_ADDR0: htrans = rdqf_pkg::HTRANS_NONSEQ;
      RDQF_ADDR1: begin
        htrans = rdqf_pkg::HTRANS_SEQ;
        haddr  = cur_q + rdqf_pkg::WORD_BYTES;
      end
      default: ;
    endcase
  end

  assign hburst = rdqf_pkg::HBURST_INCR;
  assign hsize  = rdqf_pkg::HSIZE_WORD;
  assign hwrite = 1'b0;
  assign hwdata = 32'h0000_0000;

  rdqf_desc_slot u_slot (
    .pclk               (pclk),
    .presetn            (presetn),
    .load_valid         (load_valid),
    .load_addr          (word0_q),
    .load_ctrl          (hrdata),
    .load_ready         (load_ready),
    .frame_in_progress  (frame_in_progress),
    .buf_take           (buf_take),
    .buf_valid          (buf_valid),
    .buf_addr           (buf_addr),
    .buf_byte_length    (buf_byte_length),
    .buf_tag            (buf_tag),
    .buf_no_frame_start (buf_no_frame_start),
    .last_disp          (last_disp)
  );

endmodule

/* tb/rdqf_fetch_properties.sv */
/* Checker for rdqf_fetch: AHB burst shape, slot hand-off, APB answer.
   Assumes it is bound to the fetch top and sees only its ports. */
`timescale 1ns/10ps
module rdqf_fetch_properties (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Watched ports.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hburst,
  input wire logic [2:0]  hsize,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        frame_in_progress,
  input wire logic        buf_take,
  input wire logic        buf_valid,
  input wire logic [31:0] buf_addr,
  input wire logic [15:0] buf_byte_length,
  input wire logic [14:0] buf_tag,
  input wire logic        buf_no_frame_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_ANSWER:
    assert property (psel && penable && paddr[1:0] == 2'h0 |-> pready && pslverr == (paddr > 8'h14))
      else $error("apb answer wrong");
  AST_BURST_SEQ:
    assert property (htrans == 2'h2 && hready |=> htrans == 2'h3 && haddr == $past(haddr) + 32'h4)
      else $error("second beat wrong");
  AST_BURST_END:
    assert property (htrans == 2'h3 && hready |=> htrans == 2'h0) else $error("burst too long");
  AST_BURST_KIND:
    assert property (htrans != 2'h0 |-> hburst == 3'h1 && hsize == 3'h2 && !hwrite)
      else $error("burst kind wrong");
  AST_WAIT_HOLD:
    assert property (htrans != 2'h0 && !hready |=> $stable(haddr) && $stable(htrans))
      else $error("address moved in wait");
  AST_ZERO_SKIP:
    assert property (buf_valid |-> buf_byte_length != 16'h0) else $error("zero buffer offered");
  AST_NO_FRAME_START_FLAG_DROP:
    assert property (buf_no_frame_start && !frame_in_progress |-> !buf_valid)
      else $error("flagged buffer kept");
  AST_SLOT_HOLD:
    assert property (buf_valid && !buf_take && (frame_in_progress || !buf_no_frame_start)
      |=> buf_valid && $stable(buf_tag) && $stable(buf_addr)) else $error("slot changed");
  AST_TAKE_CLEAR:
    assert property (buf_valid && buf_take |=> !buf_valid) else $error("slot not freed");
endmodule

/* tb/rdqf_ahb_mem.sv */
/* Host memory partner: answers AHB reads from a word array.
   Assumes word addresses within a 64-byte window; slow adds wait states. */
`timescale 1ns/10ps
module rdqf_ahb_mem (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // AHB slave side.
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  output logic [31:0]      hrdata,
  output logic             hready,
  output logic             hresp,
  // Bench control.
  input  wire logic        slow
);
  logic [31:0] mem [16];
  logic [3:0]  a_q;
  logic        dv_q;
  logic        ws_q;
  // Outside a data phase the inverse shows, so stale data never looks valid.
  assign hrdata = dv_q ? mem[a_q] : ~mem[a_q];
  assign hready = !(slow && ws_q);
  assign hresp  = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_q <= 1'b0;
      a_q  <= 4'h0;
      ws_q <= 1'b0;
    end else begin
      ws_q <= !ws_q;
      if (hready) begin
        dv_q <= htrans[1];
        a_q  <= haddr[5:2];
      end
    end
  end
endmodule

/* tb/tb_top.sv */
/* Bench for rdqf_fetch: APB tasks program the queue, the memory partner
   serves descriptors, tests compare read-back and the buffer ports.
   Assumes the partner and checker files are compiled first. */
`timescale 1ns/10ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        frame_in_progress = 1'b0;
  logic        buf_take = 1'b0;
  logic        buf_valid;
  logic [31:0] buf_addr;
  logic [15:0] buf_byte_length;
  logic [14:0] buf_tag;
  logic        buf_no_frame_start;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic        perr;
  int          err_total = 0;
  int          checked = 0;
  localparam logic [31:0] DESC [8] = '{32'h1000, 32'h0005_0000, 32'h2000, 32'h8006_0040,
    32'h3000, 32'h0007_0080, 32'h4000, 32'h7FFF_0100};
  always #12.5 pclk = ~pclk;
  rdqf_fetch DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .haddr, .htrans, .hburst(), .hsize(), .hwrite(), .hwdata(), .hrdata, .hready,
    .hresp, .frame_in_progress, .buf_take, .buf_valid, .buf_addr, .buf_byte_length, .buf_tag,
    .buf_no_frame_start);
  rdqf_ahb_mem u_mem (.pclk, .presetn, .haddr, .htrans, .hrdata, .hready, .hresp, .slow);
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
    // One idle edge, so that a following call never drives psel twice in one step.
    @(posedge pclk);
  endtask
  task automatic take_buf(input logic [31:0] a, input logic [31:0] info);
    int n;
    n = 0;
    while (buf_valid !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      complete_run();
    end
    chk("buf_addr", buf_addr, a);
    chk("buf_info", {buf_no_frame_start, buf_tag, buf_byte_length}, info);
    buf_take <= 1'b1;
    @(posedge pclk);
    buf_take <= 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 8; i++)
      u_mem.mem[i] = DESC[i];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk("count_reset", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", {31'h0, perr}, 32'h1);
    $display("test reset done");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h20);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h3);
    apb(1'b1, 8'h0C, 32'h2);
    apb(1'b0, 8'h0C, 32'h0);
    chk("count_sum", rd, 32'h5);
    slow <= 1'b1;
    apb(1'b1, 8'h10, 32'h1);
    take_buf(32'h3000, 32'h0007_0080);
    apb(1'b0, 8'h0C, 32'h0);
    chk("count_after", rd, 32'h2);
    take_buf(32'h4000, 32'h7FFF_0100);
    apb(1'b0, 8'h08, 32'h0);
    chk("ptr_wrap", rd, 32'h0);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk("count_empty", rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("ptr_stop", rd, 32'h8);
    apb(1'b0, 8'h14, 32'h0);
    chk("status_skip", rd, 32'h2);
    chk("skip_zero", {31'h0, buf_valid}, 32'h0);
    $display("test fetch done");
    slow <= 1'b0;
    frame_in_progress <= 1'b1;
    apb(1'b1, 8'h0C, 32'h1);
    take_buf(32'h2000, 32'h8006_0040);
    $display("test continue done");
    complete_run();
  end
endmodule
bind rdqf_fetch rdqf_fetch_properties u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .haddr, .htrans, .hburst, .hsize, .hwrite, .hready, .frame_in_progress, .buf_take,
  .buf_valid, .buf_addr, .buf_byte_length, .buf_tag, .buf_no_frame_start);
